// ---- rtl/modulo_bitrev_address_gen.sv ----
// Modulo (circular buffer) and bit-reversed correction for the X read,
// X write and Y address generators, with an Avalon-MM register port.
// Assumes decode presents the selected W pointer, modifier and mode,
// and that all inputs are synchronous to clk.
//
// Notes on behaviour
// RULE1: One circular buffer in X space, one in Y; X also covers program space.
// RULE2: Modulo correction applies to any selected W pointer, any address calculation.
// RULE3: Software should not use frame or stack pointer as circular pointers.
// RULE4: Separate 16-bit start and end registers per space, software loaded.
// RULE5: Y modulo addresses treat data as words; address bit 0 cleared.
// RULE6: Length follows from end minus start; no length register; up to 32K words.
// RULE7: X select in mode control bits 3:0; 15 disables both X generators.
// RULE8: X modulo active when X select is not 15 and bit 15 set.
// RULE9: Y select bits 7:4; active when not 15 and bit 14 set.
// RULE10: Incrementing buffers check upper bound, decrementing buffers lower bound.
// RULE11: Checks catch addresses past a bound, so overshooting steps still wrap.
// RULE12: Power-of-two buffers check both bounds, usable in either direction.
// RULE13: Write back wrapped pointer only for pre/post modify; offset mode leaves it.
// RULE14: Bit reversal only in X generator and only for data writes.
// RULE15: Only the modifier is bit-reversed; source and destination stay normal.
// RULE16: Bit reversal needs select not 15, enable bit 15, pre/post increment.
// RULE17: Software aligns a 2^N byte bit-reversed buffer start to N zero bits.
// RULE18: 15-bit pivot counts words, scaled to bytes; address bit 0 cleared.
// RULE19: Active reversal adds pivot, ignores offset; byte or other modes stay normal.
// RULE20: Both enabled: reversal wins, modulo off in X write, on in X read.
// RULE21: Software avoids indirect read right after writing bit-reverse control.
// RULE22: Reversal reverses index bit order: 1 to 8, 2 to 4, 3 to 12.
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

module modulo_bitrev_address_gen
   import addr_gen_pkg::*;
(
   input wire logic clk, // Core clock, 125 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic [4:0] address, // Avalon byte address
   input wire logic read, // Avalon read request
   input wire logic write, // Avalon write request
   input wire logic [3:0] byteenable, // Avalon byte lanes
   input wire logic [31:0] writedata, // Avalon write data
   output logic [31:0] readdata, // Avalon read data, registered
   output logic waitrequest, // Avalon stall
   input wire agen_req_t xr_req, // X read generator request
   input wire agen_req_t xw_req, // X write generator request
   input wire agen_req_t y_req, // Y generator request
   output agen_rsp_t xr_rsp, // X read generator answer
   output agen_rsp_t xw_rsp, // X write generator answer
   output agen_rsp_t y_rsp // Y generator answer
);

   // Reverse the order of a 15-bit word index
   function automatic logic [14:0] rev15(input logic [14:0] v);
      logic [14:0] r;
      r = 15'h0000;
      for (int i = 0; i < 15; i++) begin
         r[i] = v[14 - i];
      end
      return r;
   endfunction

   // Merge the two low byte lanes of a write into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [15:0] m;
      m = old;
      if (be[0]) begin
         m[7:0] = wd[7:0];
      end
      if (be[1]) begin
         m[15:8] = wd[15:8];
      end
      return m;
   endfunction

   // Pre- or post-modify: the only modes that may update the pointer
   function automatic logic is_modify(input addr_mode_t m);
      return (m == AM_PRE_MOD) | (m == AM_POST_MOD);
   endfunction

   // Register word select; the two low address bits are ignored
   function automatic logic word_hit(input logic [4:0] a, input logic [4:0] off);
      return a[4:2] == off[4:2];
   endfunction

   // Software-visible registers
   logic [15:0] mode_ctl_reg;
   logic [15:0] x_start_reg;
   logic [15:0] x_end_reg;
   logic [15:0] y_start_reg;
   logic [15:0] y_end_reg;
   logic [15:0] brev_ctl_reg;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic ack_reg;
   logic [31:0] rdata_reg;

   // Bus handshake: every access waits exactly one cycle
   wire req_any = read | write;
   wire bus_take = req_any & ack_reg;
   wire wr_take = write & ack_reg;
   assign waitrequest = req_any & ~ack_reg;
   assign readdata = rdata_reg;

   // Write strobes per register
   wire wr_mode = wr_take & word_hit(address, OFF_MODE_CTL);
   wire wr_xs = wr_take & word_hit(address, OFF_X_START);
   wire wr_xe = wr_take & word_hit(address, OFF_X_END);
   wire wr_ys = wr_take & word_hit(address, OFF_Y_START);
   wire wr_ye = wr_take & word_hit(address, OFF_Y_END);
   wire wr_brev = wr_take & word_hit(address, OFF_BREV_CTL);

   // Read mux; unmapped words read zero
   logic [15:0] rd_mux;
   always_comb begin
      case (address[4:2])
         OFF_MODE_CTL[4:2]: rd_mux = mode_ctl_reg;
         OFF_X_START[4:2]: rd_mux = x_start_reg;
         OFF_X_END[4:2]: rd_mux = x_end_reg;
         OFF_Y_START[4:2]: rd_mux = y_start_reg;
         OFF_Y_END[4:2]: rd_mux = y_end_reg;
         OFF_BREV_CTL[4:2]: rd_mux = brev_ctl_reg;
         OFF_STATUS[4:2]: rd_mux = status_reg;
         default: rd_mux = 16'h0000;
      endcase
   end

   // Acknowledge one cycle after a request appears, then drop
   // Dropping it on the taken edge keeps a held request from being taken twice
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req_any & ~ack_reg & ~bus_take;
      end
   end

   // Read data captured while the slave stalls, stands in the ack cycle
   // Registered capture keeps the read mux out of the readdata output path
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= 32'h00000000;
      end else if (read & ~ack_reg) begin
         rdata_reg <= {16'h0000, rd_mux};
      end
   end

   // Bound registers, one pair per space
   always_ff @(posedge clk) begin
      if (rst) begin
         x_start_reg <= BOUND_RST;
         x_end_reg <= BOUND_RST;
         y_start_reg <= BOUND_RST;
         y_end_reg <= BOUND_RST;
      end else begin
         if (wr_xs) x_start_reg <= merge16(x_start_reg, writedata, byteenable); // RULE4
         if (wr_xe) x_end_reg <= merge16(x_end_reg, writedata, byteenable); // RULE4
         if (wr_ys) y_start_reg <= merge16(y_start_reg, writedata, byteenable); // RULE4
         if (wr_ye) y_end_reg <= merge16(y_end_reg, writedata, byteenable); // RULE4
      end
   end

   // Control registers; reserved mode bits are held at zero
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ctl_reg <= MODE_CTL_RST;
         brev_ctl_reg <= BREV_CTL_RST;
      end else begin
         if (wr_mode) mode_ctl_reg <= merge16(mode_ctl_reg, writedata, byteenable) & MODE_CTL_MASK;
         if (wr_brev) brev_ctl_reg <= merge16(brev_ctl_reg, writedata, byteenable);
      end
   end

   // Decoded configuration fields
   wire [3:0] x_sel = mode_ctl_reg[X_SEL_LSB +: 4]; // RULE7
   wire [3:0] y_sel = mode_ctl_reg[Y_SEL_LSB +: 4]; // RULE9
   wire [3:0] b_sel = mode_ctl_reg[B_SEL_LSB +: 4];
   wire x_circ_cfg = (x_sel != SEL_NONE) & mode_ctl_reg[X_EN_BIT]; // RULE8
   wire y_circ_cfg = (y_sel != SEL_NONE) & mode_ctl_reg[Y_EN_BIT]; // RULE9
   wire brev_cfg = (b_sel != SEL_NONE) & brev_ctl_reg[BREV_EN_BIT]; // RULE16
   wire [14:0] pivot = brev_ctl_reg[PIVOT_W-1:0]; // RULE18

   // Pointer matches of each generator against the select fields
   wire xr_x_hit = (xr_req.ptr_sel == x_sel); // RULE2
   wire xw_x_hit = (xw_req.ptr_sel == x_sel); // RULE2
   wire xw_b_hit = (xw_req.ptr_sel == b_sel); // RULE16
   wire y_y_hit = (y_req.ptr_sel == y_sel); // RULE2

   // Per-generator views; both X generators share the one X buffer,
   // which also serves program-space pointers
   agen_req_t req_a [NUM_GEN];
   agen_rsp_t rsp_a [NUM_GEN];
   logic [15:0] start_a [NUM_GEN];
   logic [15:0] end_a [NUM_GEN];
   logic circ_a [NUM_GEN];
   logic brev_a [NUM_GEN];
   logic even_a [NUM_GEN];

   assign req_a[GEN_XR] = xr_req;
   assign req_a[GEN_XW] = xw_req;
   assign req_a[GEN_Y] = y_req;
   assign start_a[GEN_XR] = x_start_reg; // RULE1
   assign start_a[GEN_XW] = x_start_reg; // RULE1
   assign start_a[GEN_Y] = y_start_reg; // RULE1
   assign end_a[GEN_XR] = x_end_reg;
   assign end_a[GEN_XW] = x_end_reg;
   assign end_a[GEN_Y] = y_end_reg;

   // Bit reversal: X write only, word data, pre/post increment by a positive step
   wire xw_inc_mode = is_modify(xw_req.mode);
   wire xw_inc_step = ~xw_req.modifier[15] & (xw_req.modifier != 16'h0000);
   assign brev_a[GEN_XR] = 1'b0; // RULE14
   assign brev_a[GEN_Y] = 1'b0; // RULE14
   assign brev_a[GEN_XW] = brev_cfg & xw_b_hit & xw_inc_mode
                           & xw_inc_step & ~xw_req.byte_acc; // RULE16 RULE19

   // Modulo enables; reversal takes X write away from modulo, X read keeps it
   assign circ_a[GEN_XR] = x_circ_cfg & xr_x_hit; // RULE2 RULE20
   assign circ_a[GEN_XW] = x_circ_cfg & xw_x_hit
                           & ~brev_a[GEN_XW]; // RULE20
   assign circ_a[GEN_Y] = y_circ_cfg & y_y_hit; // RULE2

   // Y modulo treats every access as word data
   assign even_a[GEN_XR] = 1'b0;
   assign even_a[GEN_XW] = 1'b0;
   assign even_a[GEN_Y] = circ_a[GEN_Y]; // RULE5

   // One correction datapath per generator
   for (genvar g = 0; g < NUM_GEN; g++) begin : gen_path
      logic signed [17:0] ptr_s;
      logic signed [17:0] mod_s;
      logic signed [17:0] sum_s;
      logic signed [17:0] lo_s;
      logic signed [17:0] hi_s;
      logic [17:0] len;
      logic pow2;
      logic incr;
      logic hi_wrap;
      logic lo_wrap;
      logic [17:0] corr_s;
      logic [15:0] mod_addr;
      logic [14:0] brev_idx;
      logic [15:0] brev_addr;
      logic [15:0] new_ptr;
      logic use_new;
      logic brev_pre;
      logic [15:0] ea;
      logic wb_en;
      agen_rsp_t rsp_reg;

      // Widened operands so a step past 0 or 0xFFFF is still seen
      assign ptr_s = $signed({2'b00, req_a[g].ptr});
      assign mod_s = $signed({{2{req_a[g].modifier[15]}}, req_a[g].modifier});
      assign sum_s = ptr_s + mod_s;
      assign lo_s = $signed({2'b00, start_a[g]});
      assign hi_s = $signed({2'b00, end_a[g]});

      // Buffer length in bytes, implied by the two bounds
      // Kept wider than 16 bits so a 64 Kbyte buffer does not fold to zero
      assign len = {2'b00, end_a[g]} - {2'b00, start_a[g]} + 18'h00001; // RULE6
      assign pow2 = ((len & (len - 18'h00001)) == 18'h00000);
      assign incr = ~req_a[g].modifier[15];

      // Range checks catch overshoot, not just equality
      // Other lengths check one bound only, so such a buffer must be walked
      // in the one direction that its modifier sign gives
      assign hi_wrap = circ_a[g] & (incr | pow2) & (sum_s > hi_s); // RULE10 RULE11 RULE12
      assign lo_wrap = circ_a[g] & (~incr | pow2) & (sum_s < lo_s); // RULE10 RULE11 RULE12
      assign corr_s = hi_wrap ? 18'(sum_s - $signed(len))
                    : lo_wrap ? 18'(sum_s + $signed(len)) : 18'(sum_s); // RULE11
      assign mod_addr = even_a[g] ? {corr_s[15:1], 1'b0} : corr_s[15:0]; // RULE5

      // Reverse-carry add: the pointer word index and the pivot are both taken in reversed order
      // Carries run toward bit 0; a carry out of bit 0 is dropped on purpose
      assign brev_idx = rev15(15'(rev15(req_a[g].ptr[15:1]) + rev15(pivot))); // RULE15 RULE22
      assign brev_addr = {brev_idx, 1'b0}; // RULE18 RULE19

      // Next pointer and which modes place it on the bus
      assign new_ptr = brev_a[g] ? brev_addr : mod_addr;
      assign use_new = (req_a[g].mode == AM_PRE_MOD) | (req_a[g].mode == AM_OFFSET);
      assign wb_en = is_modify(req_a[g].mode); // RULE13

      // Pre-increment reversal puts the reversed pointer itself on the bus
      assign brev_pre = brev_a[g] & (req_a[g].mode == AM_PRE_MOD); // RULE19

      // Effective address; word-only paths clear bit 0 of the plain pointer too
      always_comb begin
         if (use_new | brev_pre) begin
            ea = new_ptr; // RULE13
         end else if (brev_a[g] | even_a[g]) begin
            ea = {req_a[g].ptr[15:1], 1'b0}; // RULE18 RULE5
         end else begin
            ea = req_a[g].ptr;
         end
      end

      // Answer registered one cycle after the request
      always_ff @(posedge clk) begin
         if (rst) begin
            rsp_reg <= '0;
         end else begin
            rsp_reg.valid <= req_a[g].valid;
            rsp_reg.ea <= ea;
            rsp_reg.wb_en <= req_a[g].valid & wb_en; // RULE13
            rsp_reg.wb_val <= wb_en ? new_ptr : req_a[g].ptr;
            rsp_reg.wrapped <= req_a[g].valid & (hi_wrap | lo_wrap);
            rsp_reg.bitrev <= req_a[g].valid & brev_a[g]; // RULE14
         end
      end

      assign rsp_a[g] = rsp_reg;
   end

   assign xr_rsp = rsp_a[GEN_XR];
   assign xw_rsp = rsp_a[GEN_XW];
   assign y_rsp = rsp_a[GEN_Y];

   // Status: live config flags plus flags of the last answered request
   // Only valid answers update the flags, so idle cycles keep the last result
   always_comb begin
      status_next = status_reg;
      status_next[0] = x_circ_cfg;
      status_next[1] = y_circ_cfg;
      status_next[2] = brev_cfg;
      for (int i = 0; i < NUM_GEN; i++) begin
         if (rsp_a[i].valid) begin
            status_next[4 + i] = rsp_a[i].wrapped;
         end
      end
      if (rsp_a[GEN_XW].valid) begin
         status_next[7] = rsp_a[GEN_XW].bitrev;
      end
      status_next[15:8] = 8'h00;
      status_next[3] = 1'b0;
   end

   // Status is read-only; writes to it are ignored
   always_ff @(posedge clk) begin
      if (rst) begin
         status_reg <= 16'h0000;
      end else begin
         status_reg <= status_next;
      end
   end

endmodule

// ---- rtl/addr_gen_pkg.sv ----
// Shared definitions for the modulo and bit-reversed address generators.
// Assumes one 125 MHz core clock and a 32-bit Avalon-MM register port.
package addr_gen_pkg;

   // Register byte offsets on the Avalon-MM port
   localparam logic [4:0] OFF_MODE_CTL = 5'h00;
   localparam logic [4:0] OFF_X_START = 5'h04;
   localparam logic [4:0] OFF_X_END = 5'h08;
   localparam logic [4:0] OFF_Y_START = 5'h0C;
   localparam logic [4:0] OFF_Y_END = 5'h10;
   localparam logic [4:0] OFF_BREV_CTL = 5'h14;
   localparam logic [4:0] OFF_STATUS = 5'h18;

   // Mode control fields
   localparam int X_SEL_LSB = 0;
   localparam int Y_SEL_LSB = 4;
   localparam int B_SEL_LSB = 8;
   localparam int Y_EN_BIT = 14;
   localparam int X_EN_BIT = 15;
   // Writable bits of mode control; bits 13:12 are reserved and read zero
   localparam logic [15:0] MODE_CTL_MASK = 16'hCFFF;

   // Bit-reverse control fields
   localparam int BREV_EN_BIT = 15;
   localparam int PIVOT_W = 15;

   // Pointer select value that means "no pointer"
   localparam logic [3:0] SEL_NONE = 4'hF;

   // Reset values
   localparam logic [15:0] MODE_CTL_RST = 16'h0FFF;
   localparam logic [15:0] BOUND_RST = 16'h0000;
   localparam logic [15:0] BREV_CTL_RST = 16'h0000;

   // Generator indices
   localparam int GEN_XR = 0;
   localparam int GEN_XW = 1;
   localparam int GEN_Y = 2;
   localparam int NUM_GEN = 3;

   // Addressing modes of one effective-address calculation
   typedef enum logic [1:0] {
      AM_INDIRECT = 2'b00,
      AM_POST_MOD = 2'b01,
      AM_PRE_MOD = 2'b10,
      AM_OFFSET = 2'b11
   } addr_mode_t;

   // Request from instruction decode to one generator
   typedef struct packed {
      logic valid;
      logic [3:0] ptr_sel;
      logic [15:0] ptr;
      logic [15:0] modifier;
      addr_mode_t mode;
      logic byte_acc;
   } agen_req_t;

   // Answer of one generator, one cycle after the request
   typedef struct packed {
      logic valid;
      logic [15:0] ea;
      logic wb_en;
      logic [15:0] wb_val;
      logic wrapped;
      logic bitrev;
   } agen_rsp_t;

endpackage

// ---- dv/modulo_bitrev_address_gen_props.sv ----
// Checker for the address generators and their register port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module modulo_bitrev_address_gen_props
   import addr_gen_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic rst, // Synchronous reset
   input wire logic [4:0] address, // Register address
   input wire logic read, // Register read
   input wire logic write, // Register write
   input wire logic [3:0] byteenable, // Byte lanes
   input wire logic [31:0] writedata, // Write data
   input wire logic [31:0] readdata, // Read data
   input wire logic waitrequest, // Stall
   input wire agen_req_t xr_req, // X read request
   input wire agen_req_t xw_req, // X write request
   input wire agen_req_t y_req, // Y request
   input wire agen_rsp_t xr_rsp, // X read answer
   input wire agen_rsp_t xw_rsp, // X write answer
   input wire agen_rsp_t y_rsp // Y answer
);
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Register port and answer timing
   wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("register access stalled more than one cycle");
   xr_valid_a: assert property (1 |=> xr_rsp.valid == $past(xr_req.valid))
      else $error("x read answer not one cycle after request");
   // Write back follows the addressing mode
   wb_mode_a: assert property (xr_req.valid |=> xr_rsp.wb_en ==
      ($past(xr_req.mode) == AM_POST_MOD || $past(xr_req.mode) == AM_PRE_MOD))
      else $error("x read write back does not match mode");
   off_keep_a: assert property (xw_req.valid && xw_req.mode == AM_OFFSET
      |=> !xw_rsp.wb_en && xw_rsp.wb_val == $past(xw_req.ptr))
      else $error("offset mode changed the pointer");
   y_word_a: assert property (y_rsp.wrapped |-> !y_rsp.ea[0])
      else $error("y circular address not word aligned");
   // Reversal lives only in the X write path
   brev_xonly_a: assert property (!xr_rsp.bitrev && !y_rsp.bitrev)
      else $error("bit reversal outside x write");
   brev_lsb_a: assert property (xw_rsp.bitrev |-> !xw_rsp.wb_val[0])
      else $error("reversed address not word aligned");
   brev_byte_a: assert property (xw_req.byte_acc |=> !xw_rsp.bitrev)
      else $error("byte access used bit reversal");
   brev_prio_a: assert property (xw_rsp.bitrev |-> !xw_rsp.wrapped)
      else $error("modulo and reversal together in x write");

   c_xwrap: cover property (xr_rsp.valid && xr_rsp.wrapped);
   c_ywrap: cover property (y_rsp.valid && y_rsp.wrapped);
   c_brev: cover property (xw_rsp.valid && xw_rsp.bitrev);
endmodule

bind modulo_bitrev_address_gen modulo_bitrev_address_gen_props chk (.clk(clk), .rst(rst),
   .address(address), .read(read), .write(write), .byteenable(byteenable),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .xr_req(xr_req), .xw_req(xw_req), .y_req(y_req), .xr_rsp(xr_rsp),
   .xw_rsp(xw_rsp), .y_rsp(y_rsp));

// ---- dv/decode_model.sv ----
// Model of instruction decode presenting requests to the three generators.
// Assumes the bench calls issue from one process only.
`timescale 1ns/1ps
module decode_model
   import addr_gen_pkg::*;
(
   input wire logic clk, // Core clock
   output agen_req_t xr_req, // X read request
   output agen_req_t xw_req, // X write request
   output agen_req_t y_req // Y request
);
   // Idle until the first request
   initial begin
      xr_req = '0;
      xw_req = '0;
      y_req = '0;
   end

   // Launch one request per generator just after an edge; held until the next call
   task automatic issue(input agen_req_t xr, input agen_req_t xw, input agen_req_t y);
      @(posedge clk);
      xr_req <= xr;
      xw_req <= xw;
      y_req <= y;
   endtask
endmodule

// ---- dv/modulo_bitrev_address_gen_tb.sv ----
// Self-checking bench for the modulo and bit-reversed address generators.
// Assumes one-cycle generator answers; bus accesses wait for waitrequest low.
`timescale 1ns/1ps
module modulo_bitrev_address_gen_tb
   import addr_gen_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest;
   agen_req_t xr_req, xw_req, y_req;
   agen_rsp_t xr_rsp, xw_rsp, y_rsp;
   int miscompares = 0;
   int comparisons = 0;

   // 125 MHz core clock
   always #4 clk = ~clk;

   decode_model pm (.clk(clk), .xr_req(xr_req), .xw_req(xw_req), .y_req(y_req));
   modulo_bitrev_address_gen uut (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .xr_req(xr_req), .xw_req(xw_req), .y_req(y_req),
      .xr_rsp(xr_rsp), .xw_rsp(xw_rsp), .y_rsp(y_rsp));

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Avalon master: hold until waitrequest is sampled low at a rising edge,
   // take read data at that edge and release right after it
   task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
      output logic [15:0] q);
      @(posedge clk);
      address <= a;
      writedata <= {16'h0000, d};
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata[15:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk(nm, q, e);
   endtask

   function automatic agen_req_t rq(input logic [3:0] s, input logic [15:0] p,
      input logic [15:0] m, input addr_mode_t md, input logic b);
      return '{1'b1, s, p, m, md, b};
   endfunction

   // Issue one request set and look at the answers once they have settled
   task automatic go(input agen_req_t a, input agen_req_t b, input agen_req_t c);
      pm.issue(a, b, c);
      @(posedge clk);
      #1;
   endtask

   task automatic t_regs;
      rdc("mode rst", OFF_MODE_CTL, MODE_CTL_RST);
      rdc("xend rst", OFF_X_END, BOUND_RST);
      wr(OFF_MODE_CTL, 16'hFFFF);
      rdc("mode rsvd", OFF_MODE_CTL, MODE_CTL_MASK);
      wr(OFF_Y_START, 16'h2000);
      rdc("ystart", OFF_Y_START, 16'h2000);
      wr(5'h1C, 16'h1234);
      rdc("unmapped", 5'h1C, 16'h0000);
   endtask

   // X buffer 0x1000..0x101F; pointers avoid the stack registers
   task automatic t_xmod;
      wr(OFF_X_START, 16'h1000);
      wr(OFF_X_END, 16'h101F);
      wr(OFF_MODE_CTL, 16'h8FF3);
      go(rq(4'h3, 16'h101E, 16'h0004, AM_POST_MOD, 1'b0),
         rq(4'h3, 16'h1000, 16'hFFFE, AM_POST_MOD, 1'b0), '0);
      chk("xr ea", xr_rsp.ea, 16'h101E);
      chk("xr wb", xr_rsp.wb_val, 16'h1002);
      chk("xw wb", xw_rsp.wb_val, 16'h101E);
      chk("xw wrap", 16'(xw_rsp.wrapped), 16'h0001);
      rdc("status", OFF_STATUS, 16'h0031);
      go(rq(4'h3, 16'h101E, 16'h0004, AM_OFFSET, 1'b0),
         rq(4'h5, 16'h101E, 16'h0004, AM_POST_MOD, 1'b0), '0);
      chk("off ea", xr_rsp.ea, 16'h1002);
      chk("off wb", 16'(xr_rsp.wb_en), 16'h0000);
      chk("other w", xw_rsp.wb_val, 16'h1022);
      go(rq(4'h3, 16'h101E, 16'h0004, AM_PRE_MOD, 1'b0),
         rq(4'h3, 16'h101E, 16'h0004, AM_OFFSET, 1'b0), '0);
      chk("xr pre ea", xr_rsp.ea, 16'h1002);
      chk("xr pre wb", 16'(xr_rsp.wb_en), 16'h0001);
      chk("xw off ea", xw_rsp.ea, 16'h1002);
      chk("xw off wb", xw_rsp.wb_val, 16'h101E);
      wr(OFF_MODE_CTL, 16'h0FF3);
      go(rq(4'h3, 16'h101E, 16'h0004, AM_POST_MOD, 1'b0), '0, '0);
      chk("x off", xr_rsp.wb_val, 16'h1022);
   endtask

   // Y buffer of 16 bytes, X select left at 15
   task automatic t_ymod;
      wr(OFF_Y_END, 16'h200F);
      wr(OFF_MODE_CTL, 16'h4F4F);
      go(rq(4'h4, 16'h101E, 16'h0004, AM_POST_MOD, 1'b0), '0,
         rq(4'h4, 16'h200E, 16'h0002, AM_POST_MOD, 1'b0));
      chk("x none", xr_rsp.wb_val, 16'h1022);
      chk("y wb", y_rsp.wb_val, 16'h2000);
      chk("y wrap", 16'(y_rsp.wrapped), 16'h0001);
      go('0, '0, rq(4'h4, 16'h2007, 16'h0002, AM_POST_MOD, 1'b0));
      chk("y lsb", y_rsp.ea, 16'h2006);
      go('0, '0, rq(4'h4, 16'h2007, 16'h0002, AM_INDIRECT, 1'b0));
      chk("y ind ea", y_rsp.ea, 16'h2006);
      chk("y ind wb", 16'(y_rsp.wb_en), 16'h0000);
   endtask

   function automatic logic [15:0] slot(input logic [3:0] k);
      return 16'h0800 + {11'h000, k[0], k[1], k[2], k[3], 1'b0};
   endfunction

   // 16-word reversed buffer at an aligned start, modulo on as well
   task automatic t_brev;
      wr(OFF_X_START, 16'h0800);
      wr(OFF_X_END, 16'h081F);
      wr(OFF_MODE_CTL, 16'h82F2);
      wr(OFF_BREV_CTL, 16'h8008);
      wr(OFF_Y_START, 16'h2000); // Gap before any read through the pointer
      for (int i = 0; i < 16; i++) begin
         go(rq(4'h2, 16'h081E, 16'h0002, AM_POST_MOD, 1'b0),
            rq(4'h2, slot(i[3:0]), 16'h0002, AM_POST_MOD, 1'b0), '0);
         chk("brev wb", xw_rsp.wb_val, slot(i[3:0] + 4'h1));
         chk("brev ea", xw_rsp.ea, slot(i[3:0]));
         chk("brev on", 16'(xw_rsp.bitrev), 16'h0001);
         chk("xr mod", 16'(xr_rsp.wrapped), 16'h0001);
         chk("xr norm", 16'(xr_rsp.bitrev), 16'h0000);
      end
      go('0, rq(4'h2, 16'h0800, 16'h0002, AM_POST_MOD, 1'b1), '0);
      chk("byte wb", xw_rsp.wb_val, 16'h0802);
      go('0, rq(4'h2, 16'h0800, 16'h0002, AM_PRE_MOD, 1'b0), '0);
      chk("pre ea", xw_rsp.ea, 16'h0810);
   endtask

   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Watchdog far beyond the roughly 130 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      final_report;
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_xmod;
      t_ymod;
      t_brev;
      final_report;
   end
endmodule
